// File: src/gsr_defines.vh
// Purpose: Constants for the gauge status readout bank.
// Assumes: Included by its bare name from the bank module.
// Notes: Offsets are register indices; the bus byte address is index times four.
`ifndef GSR_DEFINES_VH
`define GSR_DEFINES_VH
`define GSR_IDX_W 8
`define GSR_IDX_FLAGS 8'h0a
`define GSR_IDX_NOMREM 8'h0c
`define GSR_IDX_NOMFULL 8'h0e
`define GSR_IDX_SELREM 8'h10
`define GSR_IDX_SELFULL 8'h12
`define GSR_IDX_MEANCUR 8'h14
`define GSR_IDX_RUNTIME 8'h16
`define GSR_IDX_RAWREM 8'h18
`define GSR_IDX_IDLECUR 8'h1a
`define GSR_IDX_SMOOTHREM 8'h1c
`define GSR_IDX_PROGCUR 8'h1e
`define GSR_IDX_PROGVOLT 8'h20
`define GSR_IDX_RAWFULL 8'h22
`define GSR_IDX_MEANPWR 8'h24
`define GSR_IDX_CTRL 8'h40
`define GSR_IDX_IRQSTAT 8'h41
`define GSR_IDX_IRQMASK 8'h42
`define GSR_IDX_STBYINIT 8'h43
`define GSR_IDX_DEADBAND 8'h44
`define GSR_CTRL_SMOOTH 0
`define GSR_EV_W 7
`define GSR_EV_TICK 0
`define GSR_EV_OT 1
`define GSR_EV_UT 2
`define GSR_EV_FC 3
`define GSR_EV_SYSTEM_SHUTDOWN_FLAG 4
`define GSR_EV_BATDET 5
`define GSR_EV_STBY 6
`define GSR_RST_CTRL 1'h0
`define GSR_RST_MASK 7'h00
`define GSR_RST_STBYINIT 16'hfff6
`define GSR_RST_DEADBAND 16'h0005
`define GSR_CLK_HZ 50000000
`define GSR_TICK_S 1
`define GSR_CUR_OFS 16'h0200
`define GSR_CUR_MASK 16'hffc0
`define GSR_VOLT_OFS 16'h0db0
`define GSR_VOLT_MASK 16'hfff0
`define GSR_TTE_IDLE 16'hffff
`define GSR_FILT_SH 4
`endif

// File: src/gsr_readout_bank.v
// Purpose: Readout bank of a battery gauge, read-only except its own control words, reached over AHB-Lite.
// Assumes: Gauge core inputs share clk; the core keeps values steady between ticks.
// Notes: Value words are snapshotted once per second so a host read is coherent.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gsr_defines.vh"

module gsr_readout_bank #(
	parameter TICK_CYCLES = `GSR_TICK_S * `GSR_CLK_HZ
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	// Status flags from the gauge core
	input wire overTemperature,
	input wire underTemperature,
	input wire calibrationActive,
	input wire halfCurrentMode,
	input wire hostModeChargerControl,
	input wire fullChargeReached,
	input wire chargingAllowed,
	input wire openCircuitReadingGood,
	input wire awaitingPackIdentification,
	input wire batteryPresent,
	input wire chargeThresholdOne,
	input wire systemShutdownFlag,
	input wire dischargingFlag,
	// Values from the gauge algorithm
	input wire [15:0] nomRemCapIn,
	input wire [15:0] nomFullCapIn,
	input wire [15:0] rawRemCapIn,
	input wire [15:0] smoothRemCapIn,
	input wire [15:0] rawFullCapIn,
	input wire [15:0] smoothFullCapIn,
	input wire [15:0] meanCurrentIn,
	input wire [15:0] runTimeIn,
	input wire [15:0] meanPowerIn,
	input wire [15:0] calcChargeCurrentIn,
	input wire [15:0] calcChargeVoltageIn,
	// Outputs to the filter logic, the charger and the system
	output wire smoothingEnable,
	output wire [15:0] programmedChargeCurrent,
	output wire [15:0] programmedChargeVoltage,
	output wire irq
);

	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	function [15:0] absVal;
		input [15:0] v;
		begin
			absVal = v[15] ? (16'h0000 - v) : v;
		end
	endfunction

	// Values below the offset, or negative, clamp to the offset.
	function [15:0] quant;
		input [15:0] v;
		input [15:0] ofs;
		input [15:0] mask;
		begin
			if (v[15] || v < ofs)
				quant = ofs;
			else
				quant = ofs + ((v - ofs) & mask);
		end
	endfunction

	// Bus state
	reg wrPend_r;
	reg [7:0] wrIdx_r;
	reg [31:0] hrdata_r;
	// Snapshot registers
	reg [15:0] flags_r;
	reg [15:0] flagsPrev_r;
	reg flagsPrimed_r;
	reg [15:0] nomRem_r;
	reg [15:0] nomFull_r;
	reg [15:0] rawRem_r;
	reg [15:0] smoothRem_r;
	reg [15:0] rawFull_r;
	reg [15:0] smoothFull_r;
	reg [15:0] meanCur_r;
	reg [15:0] runTime_r;
	reg [15:0] meanPwr_r;
	reg [15:0] progCur_r;
	reg [15:0] progVolt_r;
	// Idle current filter
	reg [15:0] stby_r;
	reg [15:0] stbyPend_r;
	reg [1:0] runLen_r;
	reg stbyMeasured_r;
	// Software registers and the refresh tick counter
	reg smooth_r;
	reg [15:0] stbyInit_r;
	reg [15:0] deadband_r;
	reg [`GSR_EV_W-1:0] irqStat_r;
	reg [`GSR_EV_W-1:0] irqMask_r;
	reg [31:0] tickCnt_r;
	reg tick_r;

	wire addrOk;
	wire [7:0] reqIdx;
	wire accept;
	wire [15:0] flagsNow;
	wire [15:0] idleCur;
	wire [15:0] meanMag;
	wire [16:0] twiceInit;
	wire qualify;
	wire [16:0] diff;
	wire [15:0] stbyBase;
	wire [15:0] stbyNxt;
	wire [15:0] calcCurEff;
	wire [`GSR_EV_W-1:0] events;
	wire [`GSR_EV_W-1:0] clearBits;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign accept = hsel && htrans[1] && hready;
	assign reqIdx = haddr[9:2];
	assign addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);

	// Status word assembled from the core flags; the unused bits stay zero.
	assign flagsNow = {overTemperature, underTemperature, 1'b0, calibrationActive,
		halfCurrentMode, hostModeChargerControl, fullChargeReached,
		chargingAllowed,
		2'b00, openCircuitReadingGood, awaitingPackIdentification, batteryPresent,
		chargeThresholdOne, systemShutdownFlag, dischargingFlag};

	// Until the first accepted sample the programmed initial value is reported.
	assign idleCur = stbyMeasured_r ? stby_r : stbyInit_r;
	assign meanMag = absVal(meanCurrentIn);
	assign twiceInit = {absVal(stbyInit_r), 1'b0};
	assign qualify = (meanMag > deadband_r) && ({1'b0, meanMag} <= twiceInit);
	assign stbyBase = stbyMeasured_r ? stby_r : stbyInit_r;
	assign diff = {stbyPend_r[15], stbyPend_r} - {stbyBase[15], stbyBase};
	// Old plus one sixteenth of the step is fifteen sixteenths old, one new.
	// The arithmetic shift rounds down, so a rising value may settle up to
	// fifteen counts below the sample; a falling one always moves.
	assign stbyNxt = stbyBase + {{3{diff[16]}}, diff[16:4]};

	// Half-current mode programs half of the calculated current.
	assign calcCurEff = halfCurrentMode ? {calcChargeCurrentIn[15], calcChargeCurrentIn[15:1]}
		: calcChargeCurrentIn;

	assign events[`GSR_EV_TICK] = tick_r;
	assign events[`GSR_EV_OT] = flags_r[15] && !flagsPrev_r[15];
	assign events[`GSR_EV_UT] = flags_r[14] && !flagsPrev_r[14];
	assign events[`GSR_EV_FC] = flags_r[9] && !flagsPrev_r[9];
	assign events[`GSR_EV_SYSTEM_SHUTDOWN_FLAG] = flags_r[1] && !flagsPrev_r[1];
	assign events[`GSR_EV_BATDET] = flags_r[3] != flagsPrev_r[3];
	assign events[`GSR_EV_STBY] = tick_r && qualify && runLen_r == 2'd2;
	assign clearBits = (wrPend_r && wrIdx_r == `GSR_IDX_IRQSTAT)
		? hwdata[`GSR_EV_W-1:0] : {`GSR_EV_W{1'b0}};

	assign irq = |(irqStat_r & irqMask_r);
	assign smoothingEnable = smooth_r;
	assign programmedChargeCurrent = progCur_r;
	assign programmedChargeVoltage = progVolt_r;

	function [31:0] readMux;
		input [7:0] idx;
		begin
			case (idx)
				`GSR_IDX_FLAGS: readMux = {16'h0000, flags_r};
				`GSR_IDX_NOMREM: readMux = {16'h0000, nomRem_r};
				`GSR_IDX_NOMFULL: readMux = {16'h0000, nomFull_r};
				`GSR_IDX_SELREM: readMux = {16'h0000, smooth_r ? smoothRem_r : rawRem_r};
				`GSR_IDX_SELFULL: readMux = {16'h0000, smooth_r ? smoothFull_r : rawFull_r};
				`GSR_IDX_MEANCUR: readMux = {16'h0000, meanCur_r};
				`GSR_IDX_RUNTIME: readMux = {16'h0000, runTime_r};
				`GSR_IDX_RAWREM: readMux = {16'h0000, rawRem_r};
				`GSR_IDX_IDLECUR: readMux = {16'h0000, idleCur};
				`GSR_IDX_SMOOTHREM: readMux = {16'h0000, smoothRem_r};
				`GSR_IDX_PROGCUR: readMux = {16'h0000, progCur_r};
				`GSR_IDX_PROGVOLT: readMux = {16'h0000, progVolt_r};
				`GSR_IDX_RAWFULL: readMux = {16'h0000, rawFull_r};
				`GSR_IDX_MEANPWR: readMux = {16'h0000, meanPwr_r};
				`GSR_IDX_CTRL: readMux = {31'h00000000, smooth_r};
				`GSR_IDX_IRQSTAT: readMux = {25'h0000000, irqStat_r};
				`GSR_IDX_IRQMASK: readMux = {25'h0000000, irqMask_r};
				`GSR_IDX_STBYINIT: readMux = {16'h0000, stbyInit_r};
				`GSR_IDX_DEADBAND: readMux = {16'h0000, deadband_r};
				default: readMux = 32'h00000000;
			endcase
		end
	endfunction

	// Read data is fetched at the address phase so it stands from a flip-flop.
	always @(posedge clk)
	begin
		if (rst)
		begin
			wrPend_r <= 1'b0;
			wrIdx_r <= 8'h00;
			hrdata_r <= 32'h00000000;
		end
		else
		begin
			wrPend_r <= accept && hwrite && addrOk;
			if (accept)
				wrIdx_r <= reqIdx;
			if (accept && !hwrite)
				hrdata_r <= addrOk ? readMux(reqIdx) : 32'h00000000;
		end
	end

	// Only the own control words take writes; every gauge code ignores them.
	always @(posedge clk)
	begin
		if (rst)
		begin
			smooth_r <= `GSR_RST_CTRL;
			irqMask_r <= `GSR_RST_MASK;
			stbyInit_r <= `GSR_RST_STBYINIT;
			deadband_r <= `GSR_RST_DEADBAND;
		end
		else if (wrPend_r)
		begin
			case (wrIdx_r)
				`GSR_IDX_CTRL: smooth_r <= hwdata[`GSR_CTRL_SMOOTH];
				`GSR_IDX_IRQMASK: irqMask_r <= hwdata[`GSR_EV_W-1:0];
				`GSR_IDX_STBYINIT: stbyInit_r <= hwdata[15:0];
				`GSR_IDX_DEADBAND: deadband_r <= hwdata[15:0];
				default: smooth_r <= smooth_r;
			endcase
		end
	end

	// A new event in the cycle of a clear keeps its bit set.
	always @(posedge clk)
	begin
		if (rst)
			irqStat_r <= {`GSR_EV_W{1'b0}};
		else
			irqStat_r <= (irqStat_r & ~clearBits) | events;
	end

	// One-second tick for the periodic refresh.
	always @(posedge clk)
	begin
		if (rst)
		begin
			tickCnt_r <= 32'h00000000;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= tickCnt_r == TICK_LAST;
			if (tickCnt_r == TICK_LAST)
				tickCnt_r <= 32'h00000000;
			else
				tickCnt_r <= tickCnt_r + 32'h00000001;
		end
	end

	// Flags follow the core every cycle; the previous copy feeds edge events.
	always @(posedge clk)
	begin
		if (rst)
		begin
			flags_r <= 16'h0000;
			flagsPrev_r <= 16'h0000;
			flagsPrimed_r <= 1'b0;
		end
		else
		begin
			flags_r <= flagsNow;
			flagsPrimed_r <= 1'b1;
			// A flag already set at reset release is a level, not an edge.
			if (flagsPrimed_r)
				flagsPrev_r <= flags_r;
			else
				flagsPrev_r <= flagsNow;
		end
	end

	// Value words change only on the tick, so a host never sees a half update.
	always @(posedge clk)
	begin
		if (rst)
		begin
			nomRem_r <= 16'h0000;
			nomFull_r <= 16'h0000;
			rawRem_r <= 16'h0000;
			smoothRem_r <= 16'h0000;
			rawFull_r <= 16'h0000;
			smoothFull_r <= 16'h0000;
			meanCur_r <= 16'h0000;
			runTime_r <= `GSR_TTE_IDLE;
			meanPwr_r <= 16'h0000;
			progCur_r <= `GSR_CUR_OFS;
			progVolt_r <= `GSR_VOLT_OFS;
		end
		else if (tick_r)
		begin
			nomRem_r <= nomRemCapIn;
			nomFull_r <= nomFullCapIn;
			rawRem_r <= rawRemCapIn;
			smoothRem_r <= smoothRemCapIn;
			rawFull_r <= rawFullCapIn;
			smoothFull_r <= smoothFullCapIn;
			meanCur_r <= meanCurrentIn;
			runTime_r <= dischargingFlag ? runTimeIn : `GSR_TTE_IDLE;
			// Power is kept while discharging or charging and is zero when idle.
			if (dischargingFlag || (!meanCurrentIn[15] && meanCurrentIn != 16'h0000))
				meanPwr_r <= meanPowerIn;
			else
				meanPwr_r <= 16'h0000;
			progCur_r <= quant(calcCurEff, `GSR_CUR_OFS, `GSR_CUR_MASK);
			progVolt_r <= quant(calcChargeVoltageIn, `GSR_VOLT_OFS, `GSR_VOLT_MASK);
		end
	end

	// Each qualifying sample waits one tick; it is used only if the next also
	// qualifies, which drops the last of a run, and the first is never used.
	always @(posedge clk)
	begin
		if (rst)
		begin
			stby_r <= 16'h0000;
			stbyPend_r <= 16'h0000;
			runLen_r <= 2'd0;
			stbyMeasured_r <= 1'b0;
		end
		else if (tick_r)
		begin
			if (qualify)
			begin
				stbyPend_r <= meanCurrentIn;
				if (runLen_r != 2'd2)
					runLen_r <= runLen_r + 2'd1;
				if (runLen_r == 2'd2)
				begin
					stby_r <= stbyNxt;
					stbyMeasured_r <= 1'b1;
				end
			end
			else
				runLen_r <= 2'd0;
		end
	end

endmodule
`default_nettype wire

// File: dv/gsr_readout_bank_asserts.sv
// Purpose: Port-level checks for the gauge status readout bank.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Bound into every instance of the bank.
`timescale 1ns/1ps
`default_nettype none
module gsr_readout_bank_asserts (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Outputs
	input wire smoothingEnable,
	input wire [15:0] programmedChargeCurrent,
	input wire [15:0] programmedChargeVoltage
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence rdTaken;
		hsel && htrans[1] && !hwrite;
	endsequence
	sequence ctlWrite;
		hsel && htrans[1] && hwrite && haddr == 32'h0000_0100;
	endsequence
	hready_ok_a:
	assert property (hreadyout && !hresp) else $error("wait state or error response");
	upper_zero_a:
	assert property (rdTaken |=> hrdata[31:16] == 16'h0000) else $error("upper half not zero");
	unmapped_zero_a:
	assert property (rdTaken ##0 haddr >= 32'h400 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	hold_data_a:
	assert property (!(hsel && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	smooth_wr_a:
	assert property (ctlWrite |=> ##1 smoothingEnable == $past(hwdata[0]))
		else $error("smoothing bit not taken from write data");
	smooth_only_a:
	assert property ($changed(smoothingEnable) |-> $past(hsel && htrans[1] && hwrite
		&& haddr == 32'h0000_0100, 2)) else $error("smoothing changed without write");
	cur_reset_a:
	assert property ($fell(rst) |-> programmedChargeCurrent == 16'h0200)
		else $error("charge current not at offset after reset");
	volt_reset_a:
	assert property ($fell(rst) |-> programmedChargeVoltage == 16'h0db0)
		else $error("charge voltage not at offset after reset");
	cur_quant_a:
	assert property (programmedChargeCurrent[5:0] == 6'h00 && programmedChargeCurrent >= 16'h0200)
		else $error("charge current off its grid");
	volt_quant_a:
	assert property (programmedChargeVoltage[3:0] == 4'h0 && programmedChargeVoltage >= 16'h0db0)
		else $error("charge voltage off its grid");
endmodule
bind gsr_readout_bank gsr_readout_bank_asserts gsr_readout_bank_asserts_i (
	.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .smoothingEnable(smoothingEnable),
	.programmedChargeCurrent(programmedChargeCurrent),
	.programmedChargeVoltage(programmedChargeVoltage)
);
`default_nettype wire

// File: dv/gsr_host_model.sv
// Purpose: Host processor model issuing word reads and writes.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes: No wait limit here; the bench watchdog ends a hang.
`timescale 1ns/1ps
`default_nettype none
module gsr_host_model (
	// Clock
	input wire clk,
	// Bus master side
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire hready,
	input wire [31:0] hrdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end
	// Whole words only, so an even/odd code pair is never split.
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge clk); while (!hready);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (!hready);
		r = hrdata;
	endtask
endmodule
`default_nettype wire

// File: dv/gsr_tb.sv
// Purpose: Self-checking bench for the gauge status readout bank.
// Assumes: Core values held steady; tick shortened to 20 cycles.
// Notes: Table of code reads, then odd cases, interrupt and a mid-run reset.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int TICK = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic overTemperature = 1'b1, underTemperature = 1'b0, calibrationActive = 1'b1;
	logic halfCurrentMode = 1'b0, hostModeChargerControl = 1'b1, fullChargeReached = 1'b0;
	logic chargingAllowed = 1'b1, openCircuitReadingGood = 1'b1, batteryPresent = 1'b1;
	logic awaitingPackIdentification = 1'b0, chargeThresholdOne = 1'b0;
	logic systemShutdownFlag = 1'b1, dischargingFlag = 1'b1;
	logic [15:0] nomRemCapIn = 16'h0101, nomFullCapIn = 16'h0202, rawRemCapIn = 16'h0303;
	logic [15:0] smoothRemCapIn = 16'h0404, rawFullCapIn = 16'h0505, smoothFullCapIn = 16'h0606;
	logic [15:0] meanCurrentIn = 16'hffce, runTimeIn = 16'h0064, meanPowerIn = 16'hff00;
	logic [15:0] calcChargeCurrentIn = 16'h0555, calcChargeVoltageIn = 16'h1068;
	wire hsel, hwrite, hreadyout, hresp, smoothingEnable, irq;
	wire hready = hreadyout;
	wire [1:0] htrans;
	wire [2:0] hsize;
	wire [31:0] haddr, hwdata, hrdata;
	wire [15:0] programmedChargeCurrent, programmedChargeVoltage;
	int n_errors = 0;
	int comparisons = 0;
	logic [31:0] r;
	// Byte address beside the word it should read back.
	logic [24:0] rows [14] = '{
		{9'h028, 16'h952b},
		{9'h030, 16'h0101},
		{9'h038, 16'h0202},
		{9'h040, 16'h0303},
		{9'h048, 16'h0505},
		{9'h050, 16'hffce},
		{9'h058, 16'h0064},
		{9'h060, 16'h0303},
		{9'h068, 16'hfff6},
		{9'h070, 16'h0404},
		{9'h078, 16'h0540},
		{9'h080, 16'h1060},
		{9'h088, 16'h0505},
		{9'h090, 16'hff00}
	};
	gsr_readout_bank #(.TICK_CYCLES(TICK)) gsr_readout_bank_i (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.overTemperature(overTemperature), .underTemperature(underTemperature),
		.calibrationActive(calibrationActive), .halfCurrentMode(halfCurrentMode),
		.hostModeChargerControl(hostModeChargerControl),
		.fullChargeReached(fullChargeReached), .chargingAllowed(chargingAllowed),
		.openCircuitReadingGood(openCircuitReadingGood),
		.awaitingPackIdentification(awaitingPackIdentification),
		.batteryPresent(batteryPresent), .chargeThresholdOne(chargeThresholdOne),
		.systemShutdownFlag(systemShutdownFlag), .dischargingFlag(dischargingFlag),
		.nomRemCapIn(nomRemCapIn), .nomFullCapIn(nomFullCapIn),
		.rawRemCapIn(rawRemCapIn), .smoothRemCapIn(smoothRemCapIn),
		.rawFullCapIn(rawFullCapIn), .smoothFullCapIn(smoothFullCapIn),
		.meanCurrentIn(meanCurrentIn), .runTimeIn(runTimeIn),
		.meanPowerIn(meanPowerIn), .calcChargeCurrentIn(calcChargeCurrentIn),
		.calcChargeVoltageIn(calcChargeVoltageIn), .smoothingEnable(smoothingEnable),
		.programmedChargeCurrent(programmedChargeCurrent),
		.programmedChargeVoltage(programmedChargeVoltage), .irq(irq)
	);
	gsr_host_model gsr_host_model_i (
		.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata)
	);
	always #10 clk = ~clk;
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d);
		gsr_host_model_i.xfer(w, a, d, r);
	endtask
	task automatic results;
		if (n_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (TICK + 6) @(posedge clk);
		foreach (rows[i])
		begin
			xf(1'b0, {23'h0, rows[i][24:16]}, 32'h0);
			chk("code read", r, {16'h0, rows[i][15:0]});
		end
		xf(1'b1, 32'h100, 32'h1);
		@(posedge clk);
		chk("smoothing", smoothingEnable, 1'b1);
		xf(1'b1, 32'h30, 32'hffff);
		xf(1'b0, 32'h400, 32'h0);
		chk("unmapped", r, 32'h0);
		dischargingFlag <= 1'b0;
		calcChargeCurrentIn <= 16'h0100;
		calcChargeVoltageIn <= 16'h0d00;
		repeat (TICK + 5) @(posedge clk);
		xf(1'b0, 32'h30, 32'h0);
		chk("ro write", r, 32'h0101);
		xf(1'b0, 32'h40, 32'h0);
		chk("sel rem", r, 32'h0404);
		xf(1'b0, 32'h48, 32'h0);
		chk("sel full", r, 32'h0606);
		xf(1'b0, 32'h58, 32'h0);
		chk("idle run time", r, 32'hffff);
		xf(1'b0, 32'h90, 32'h0);
		chk("idle power", r, 32'h0);
		chk("low current", programmedChargeCurrent, 16'h0200);
		chk("low voltage", programmedChargeVoltage, 16'h0db0);
		xf(1'b0, 32'h104, 32'h0);
		chk("no reset edge", r[1], 1'b0);
		overTemperature <= 1'b0;
		repeat (4) @(posedge clk);
		overTemperature <= 1'b1;
		repeat (4) @(posedge clk);
		chk("masked irq", irq, 1'b0);
		xf(1'b0, 32'h104, 32'h0);
		chk("status bit", r[1], 1'b1);
		xf(1'b1, 32'h108, 32'h2);
		@(posedge clk);
		chk("raised irq", irq, 1'b1);
		xf(1'b1, 32'h104, 32'h2);
		@(posedge clk);
		chk("cleared irq", irq, 1'b0);
		rst <= 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("reset irq", irq, 1'b0);
		chk("reset ctrl", smoothingEnable, 1'b0);
		xf(1'b0, 32'h10c, 32'h0);
		chk("init standby", r, 32'hfff6);
		xf(1'b0, 32'h110, 32'h0);
		chk("deadband", r, 32'h0005);
		xf(1'b0, 32'h108, 32'h0);
		chk("mask", r, 32'h0);
		chk("reset current", programmedChargeCurrent, 16'h0200);
		// A sample inside the window; the first two ticks must leave the report alone.
		meanCurrentIn <= 16'hffec;
		repeat (2 * TICK) @(posedge clk);
		xf(1'b0, 32'h68, 32'h0);
		chk("first sample skipped", r, 32'hfff6);
		repeat (TICK) @(posedge clk);
		xf(1'b0, 32'h68, 32'h0);
		chk("idle moved", $signed(r[15:0]) < -16'sd10 && $signed(r[15:0]) >= -16'sd20, 1'b1);
		chk("idle measured", r[15:0] != 16'hfff6, 1'b1);
		results();
	end
	// The whole run needs well under a thousand cycles.
	initial
	begin
		#(20 * 2000);
		n_errors++;
		results();
	end
endmodule
`default_nettype wire
